// File: rtl/fbec_defines.vh
`ifndef FBEC_DEFINES_VH
`define FBEC_DEFINES_VH
// register indices; byte address is four times the index
`define FBEC_IDX_SYND 8'ha8
`define FBEC_IDX_FADDR 8'haa
`define FBEC_IDX_SWCHK 8'hae
`define FBEC_IDX_CONSOLE_ENTRY_BASE 8'hb0
`define FBEC_IDX_STAT 8'ha4
`define FBEC_IDX_SYSTYPE 8'hb2
`define FBEC_IDX_CTL 8'hb4
// status field positions
`define FBEC_B_HERR 0
`define FBEC_B_SERR 1
`define FBEC_B_TPERR 2
`define FBEC_B_TCPERR 3
`define FBEC_B_SEO 7
`define FBEC_B_FECC 8
`define FBEC_B_FCRD 9
`define FBEC_B_FDPERR 10
`define FBEC_B_FIRD 11
`define FBEC_B_FSEO 14
// reset values
`define FBEC_RST_CONSOLE_ENTRY_BASE 32'h0000_0000
`define FBEC_RST_SWCHK 14'h0000
`endif

// File: rtl/fbec_top.v
`include "fbec_defines.vh"
module fbec_top #(
   parameter [7:0] SYS_KIND = 8'h5a, // arbitrary value
   parameter [7:0] FW_REV = 8'h3c, // arbitrary value
   parameter [7:0] SYSTEM_VARIANT_CODE = 8'h7e, // arbitrary value
   parameter [7:0] LIC_CLASS = 8'h24 // arbitrary value
)(
   // clock and reset
   input wire ref_clk_in,
   input wire rst_b_in,
   // avalon-mm slave
   input wire [9:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // external cycle errors
   input wire bus_hard_in,
   input wire bus_soft_in,
   input wire tag_par_in,
   input wire tagctl_par_in,
   input wire [3:0] dispatch_cmd_in,
   input wire [31:0] bus_addr_in,
   // fill errors
   input wire fill_ecc_in,
   input wire fill_corr_in,
   input wire fill_par_in,
   input wire fill_instr_in,
   input wire [1:0] refill_quadword_index_in,
   input wire [31:0] fill_addr_in,
   input wire [13:0] refill_check_syndrome_in,
   // check-bit source
   input wire [13:0] gen_check_in,
   output reg [13:0] write_check_out,
   // bus error address, syndrome decode and software check enable
   output reg [31:0] bus_err_addr_out,
   output reg [6:0] synd_hi_bit_out,
   output reg [6:0] synd_lo_bit_out,
   output reg synd_hi_dbl_out,
   output reg synd_lo_dbl_out,
   output wire software_check_enable_out
);

   // -------------------------------------------------
   // syndrome decode
   // -------------------------------------------------
   // returns {double, code}; code 0..31 data, 32..38 check
   function [7:0] fbec_decode;
      input [6:0] s;
      reg [6:0] code;
      reg dbl;
      begin
         dbl = 1'b0;
         code = 7'h7f;
         case (s)
            7'h00: code = 7'h7f;
            7'h4f: code = 7'd0;
            7'h4a: code = 7'd1;
            7'h52: code = 7'd2;
            7'h54: code = 7'd3;
            7'h57: code = 7'd4;
            7'h58: code = 7'd5;
            7'h5b: code = 7'd6;
            7'h5d: code = 7'd7;
            7'h23: code = 7'd8;
            7'h25: code = 7'd9;
            7'h26: code = 7'd10;
            7'h29: code = 7'd11;
            7'h2a: code = 7'd12;
            7'h2c: code = 7'd13;
            7'h31: code = 7'd14;
            7'h34: code = 7'd15;
            7'h0e: code = 7'd16;
            7'h0b: code = 7'd17;
            7'h13: code = 7'd18;
            7'h15: code = 7'd19;
            7'h16: code = 7'd20;
            7'h19: code = 7'd21;
            7'h1a: code = 7'd22;
            7'h1c: code = 7'd23;
            7'h62: code = 7'd24;
            7'h64: code = 7'd25;
            7'h67: code = 7'd26;
            7'h68: code = 7'd27;
            7'h6b: code = 7'd28;
            7'h6d: code = 7'd29;
            7'h70: code = 7'd30;
            7'h75: code = 7'd31;
            7'h01: code = 7'd32;
            7'h02: code = 7'd33;
            7'h04: code = 7'd34;
            7'h08: code = 7'd35;
            7'h10: code = 7'd36;
            7'h20: code = 7'd37;
            7'h40: code = 7'd38;
            default: dbl = 1'b1;
         endcase
         fbec_decode = {dbl, code};
      end
   endfunction

   // -------------------------------------------------
   // dispatch command to status code
   // -------------------------------------------------
   // plain write (0110) reports 010, all else bits 3:1
   function [2:0] fbec_cmd_code;
      input [3:0] cmd;
      begin
         case (cmd)
            4'h6: fbec_cmd_code = 3'h2;
            default: fbec_cmd_code = cmd[3:1];
         endcase
      end
   endfunction

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   reg [31:0] stat;
   reg [26:0] fill_pa;
   reg [13:0] synd;
   reg synd_lock;
   reg [13:0] sw_check;
   reg sw_en;
   reg [31:0] console_base;
   wire [7:0] idx;
   wire wr;
   wire rd;
   wire bus_lock;
   wire fill_lock;
   wire [31:0] w1c;
   wire [2:0] cmd_code;
   wire bus_err;
   wire fill_err;
   wire [7:0] dec_hi;
   wire [7:0] dec_lo;

   assign idx = avs_address_in[9:2];
   assign wr = avs_write_in & (avs_byteenable_in != 4'h0);
   assign rd = avs_read_in;
   assign avs_waitrequest_out = 1'b0;
   assign software_check_enable_out = sw_en;
   assign w1c = (wr && idx == `FBEC_IDX_STAT) ? avs_writedata_in : 32'h0;
   assign bus_lock = stat[`FBEC_B_HERR] | stat[`FBEC_B_SERR] |
      stat[`FBEC_B_TPERR] | stat[`FBEC_B_TCPERR];
   assign fill_lock = stat[`FBEC_B_FECC] | stat[`FBEC_B_FDPERR];
   assign bus_err = bus_hard_in | bus_soft_in | tag_par_in | tagctl_par_in;
   assign fill_err = fill_ecc_in | fill_par_in;
   // status code per command table
   assign cmd_code = fbec_cmd_code(dispatch_cmd_in);
   assign dec_hi = fbec_decode(synd[13:7]);
   assign dec_lo = fbec_decode(synd[6:0]);

   // -------------------------------------------------
   // status, not touched by reset
   // -------------------------------------------------
   always @(posedge ref_clk_in)
   begin
      // bus side: locked fields hold, unlock on ones
      if (w1c[`FBEC_B_SEO] | (|w1c[3:0]))
      begin
         stat[3:0] <= stat[3:0] & ~w1c[3:0];
         stat[`FBEC_B_SEO] <= stat[`FBEC_B_SEO] & ~w1c[`FBEC_B_SEO];
      end
      if (bus_err)
      begin
         if (bus_lock & ~(|w1c[3:0]))
            stat[`FBEC_B_SEO] <= stat[`FBEC_B_SEO] |
               bus_hard_in | tag_par_in | tagctl_par_in;
         else
         begin
            stat[`FBEC_B_HERR] <= bus_hard_in;
            stat[`FBEC_B_SERR] <= bus_soft_in;
            stat[`FBEC_B_TPERR] <= tag_par_in;
            stat[`FBEC_B_TCPERR] <= tagctl_par_in;
            stat[6:4] <= cmd_code;
            bus_err_addr_out <= bus_addr_in;
         end
      end
      // fill side
      if (w1c[`FBEC_B_FSEO] | (|w1c[11:8]))
      begin
         stat[10:8] <= stat[10:8] & ~w1c[10:8];
         stat[`FBEC_B_FIRD] <= stat[`FBEC_B_FIRD] & ~w1c[`FBEC_B_FIRD];
         stat[`FBEC_B_FSEO] <= stat[`FBEC_B_FSEO] & ~w1c[`FBEC_B_FSEO];
      end
      if (fill_err)
      begin
         if (fill_lock & ~(|w1c[10:8]))
            stat[`FBEC_B_FSEO] <= stat[`FBEC_B_FSEO] |
               (fill_ecc_in & ~fill_corr_in) | fill_par_in;
         else
         begin
            stat[`FBEC_B_FECC] <= fill_ecc_in;
            stat[`FBEC_B_FCRD] <= fill_ecc_in & fill_corr_in;
            stat[`FBEC_B_FDPERR] <= fill_par_in;
            stat[`FBEC_B_FIRD] <= fill_instr_in;
            stat[13:12] <= refill_quadword_index_in;
         end
      end
      stat[31:15] <= 17'h0;
   end

   // -------------------------------------------------
   // fill address, syndrome, control
   // -------------------------------------------------
   always @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         synd_lock <= 1'b0;
         sw_check <= `FBEC_RST_SWCHK;
         sw_en <= 1'b0;
         console_base <= `FBEC_RST_CONSOLE_ENTRY_BASE;
         fill_pa <= 27'h0;
         synd <= 14'h0;
      end
      else
      begin
         if (rd && idx == `FBEC_IDX_FADDR)
            synd_lock <= 1'b0;
         if (fill_err && !synd_lock)
         begin
            synd_lock <= 1'b1;
            fill_pa <= fill_addr_in[31:5];
            if (fill_ecc_in)
               synd <= refill_check_syndrome_in;
         end
         if (wr && idx == `FBEC_IDX_SWCHK)
            sw_check <= avs_writedata_in[13:0];
         if (wr && idx == `FBEC_IDX_CTL)
            sw_en <= avs_writedata_in[0];
         if (wr && idx == `FBEC_IDX_CONSOLE_ENTRY_BASE)
            console_base <= avs_writedata_in;
      end
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   always @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         write_check_out <= 14'h0;
         synd_hi_bit_out <= 7'h0;
         synd_lo_bit_out <= 7'h0;
         synd_hi_dbl_out <= 1'b0;
         synd_lo_dbl_out <= 1'b0;
      end
      else
      begin
         write_check_out <= sw_en ? sw_check : gen_check_in;
         synd_hi_bit_out <= dec_hi[6:0];
         synd_lo_bit_out <= dec_lo[6:0];
         synd_hi_dbl_out <= dec_hi[7];
         synd_lo_dbl_out <= dec_lo[7];
      end
   end

   // read mux, read-only fields ignore writes
   always @*
   begin
      case (idx)
         `FBEC_IDX_STAT: avs_readdata_out = stat;
         `FBEC_IDX_SYND: avs_readdata_out = {18'h0, synd};
         `FBEC_IDX_FADDR: avs_readdata_out = {fill_pa, 5'h0};
         `FBEC_IDX_CONSOLE_ENTRY_BASE: avs_readdata_out = console_base;
         `FBEC_IDX_SYSTYPE: avs_readdata_out =
            {SYS_KIND, FW_REV, SYSTEM_VARIANT_CODE, LIC_CLASS};
         `FBEC_IDX_CTL: avs_readdata_out = {31'h0, sw_en};
         default: avs_readdata_out = 32'h0;
      endcase
   end

endmodule // fbec_top

// File: testbench/fbec_ext.sv
// ----
// external cycle and fill error source
// ----
module fbec_ext (
   // clock and requests
   input wire clk_in,
   input wire [5:0] req_in,
   input wire [31:0] addr_in,
   input wire [21:0] info_in,
   // error events and their fields
   output logic [5:0] ev_out = 6'h00,
   output logic [31:0] addr_out = 32'h0,
   output logic [21:0] info_out = 22'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk_in)
   begin
      ev_out <= req_in;
      addr_out <= |req_in ? addr_in : ~addr_out;
      info_out <= |req_in ? info_in : ~info_out;
   end
endmodule // fbec_ext

// File: testbench/fbec_props.sv
// ----
// status and register checks
// ----
module fbec_props (
   // clock and reset
   input wire ref_clk_in,
   input wire rst_b_in,
   // watched ports
   input wire [9:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [31:0] avs_readdata_out,
   input wire avs_waitrequest_out,
   input wire bus_hard_in,
   input wire bus_soft_in,
   input wire tag_par_in,
   input wire tagctl_par_in,
   input wire fill_ecc_in,
   input wire fill_par_in,
   input wire [13:0] gen_check_in,
   input wire [13:0] write_check_out,
   input wire software_check_enable_out
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [7:0] idx = avs_address_in[9:2];
   wire rd_st = avs_read_in && idx == 8'ha4;
   wire wr_cb = avs_write_in && idx == 8'hb0;
   wire wr_ctl = avs_write_in && idx == 8'hb4;
   wire wd0 = avs_writedata_in[0];
   wire bus_ev = bus_hard_in | bus_soft_in | tag_par_in | tagctl_par_in;
   wire fill_ev = fill_ecc_in | fill_par_in;
   wire any_ev = bus_ev | fill_ev;
   wire clr = avs_write_in && idx == 8'ha4
      && (avs_writedata_in & 32'h4f8f) == 32'h4f8f;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   no_wait_a: assert property (avs_read_in |-> !avs_waitrequest_out)
      else $error("waitrequest raised");
   unmapped_zero_a: assert property (avs_read_in && idx == 8'h00
      |-> avs_readdata_out == 32'h0) else $error("unmapped not zero");
   bus_flag_a: assert property ($past(bus_ev, 2) && rd_st
      |-> avs_readdata_out[3:0] != 4'h0) else $error("bus flag missing");
   fill_flag_a: assert property ($past(fill_ev, 2) && rd_st
      |-> avs_readdata_out[8] || avs_readdata_out[10])
      else $error("fill flag missing");
   clear_ones_a: assert property ($past(clr, 2) && !$past(any_ev)
      && !$past(any_ev, 2) && rd_st |-> (avs_readdata_out & 32'h4f8f) == 0)
      else $error("status not cleared");
   console_rw_a: assert property (avs_read_in && idx == 8'hb0
      && $past(wr_cb, 2) |-> avs_readdata_out == $past(avs_writedata_in, 2))
      else $error("console base lost");
   sw_enable_a: assert property ($past(wr_ctl)
      |-> software_check_enable_out == $past(wd0)) else $error("enable");
   check_src_a: assert property ($past(rst_b_in)
      && !$past(software_check_enable_out)
      |-> write_check_out == $past(gen_check_in)) else $error("check bits");
   cover property (rd_st && avs_readdata_out[7]);
   cover property (rd_st && avs_readdata_out[14]);
   cover property (software_check_enable_out);
endmodule // fbec_props
bind fbec_top fbec_props u_props (.ref_clk_in, .rst_b_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
   .avs_waitrequest_out, .bus_hard_in, .bus_soft_in, .tag_par_in,
   .tagctl_par_in, .fill_ecc_in, .fill_par_in, .gen_check_in,
   .write_check_out, .software_check_enable_out);

// File: testbench/fbec_top_test.sv
module fbec_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_in = 0, rst_b_in = 0, rd = 0, wr = 0;
   logic [9:0] adr = 0;
   logic [31:0] wdata = 0, a_in = 0, a, d, q;
   logic [21:0] i_in = 0, i;
   logic [13:0] gen = 0;
   logic [5:0] req = 0;
   logic [3:0] c;
   logic [3:0] cmds [8] = '{4'h8, 4'ha, 4'hc, 4'hd, 4'h2, 4'h6, 4'h7, 4'h1};
   integer fails = 0, n_compared = 0, seed = 32'hd8c1;
   wire [31:0] rdata, ev_a, baddr;
   wire [21:0] info;
   wire [13:0] wchk;
   wire [6:0] hb, lb;
   wire [5:0] ev;
   wire wait_r, hd, ld, en;
   always #50 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) gen <= $random(seed);
   fbec_ext u_ext (.clk_in(ref_clk_in), .req_in(req), .addr_in(a_in),
      .info_in(i_in), .ev_out(ev), .addr_out(ev_a), .info_out(info));
   fbec_top DUT (.ref_clk_in, .rst_b_in, .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_r), .bus_hard_in(ev[0]),
      .bus_soft_in(ev[1]), .tag_par_in(ev[2]), .tagctl_par_in(ev[3]),
      .dispatch_cmd_in(info[3:0]), .bus_addr_in(ev_a), .fill_ecc_in(ev[4]),
      .fill_corr_in(info[4]), .fill_par_in(ev[5]), .fill_instr_in(info[5]),
      .refill_quadword_index_in(info[7:6]), .fill_addr_in(ev_a), .refill_check_syndrome_in(info[21:8]),
      .gen_check_in(gen), .write_check_out(wchk), .bus_err_addr_out(baddr),
      .synd_hi_bit_out(hb), .synd_lo_bit_out(lb), .synd_hi_dbl_out(hd),
      .synd_lo_dbl_out(ld), .software_check_enable_out(en));
   // ----
   // tasks
   // ----
   function logic [2:0] exp_cmd(input [3:0] x);
      case (x)
         4'h8, 4'h9: return 3'h4;
         4'ha: return 3'h5;
         4'hc, 4'hd: return 3'h6;
         4'h2, 4'h3: return 3'h1;
         4'h7: return 3'h3;
         4'h6, 4'h5: return 3'h2;
         default: return 3'h0;
      endcase
   endfunction
   task chk(input string s, input [31:0] seen, input [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task bus(input w, input [7:0] x, input [31:0] v, output [31:0] r);
      @(posedge ref_clk_in);
      adr <= {x, 2'b00};
      rd <= !w;
      wr <= w;
      wdata <= v;
      @(posedge ref_clk_in);
      while (wait_r !== 1'b0) @(posedge ref_clk_in);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task fire(input [5:0] k, input [31:0] av, input [21:0] iv);
      @(posedge ref_clk_in);
      req <= k;
      a_in <= av;
      i_in <= iv;
      @(posedge ref_clk_in);
      req <= 6'h00;
      @(posedge ref_clk_in);
   endtask
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #(4000 * 100);
      fails++;
      conclude;
   end
   // ----
   // scenarios
   // ----
   initial
   begin
      repeat (8) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      a = $random(seed);
      bus(1, 8'hb0, a, d);
      bus(0, 8'hb0, 0, d);
      chk("console", d, a);
      bus(1, 8'hb2, ~a, d);
      bus(0, 8'hb2, 0, d);
      chk("systype", d, 32'h5a3c7e24);
      bus(0, 8'h00, 0, d);
      chk("unmapped", d, 0);
      bus(1, 8'ha4, 32'h4f8f, d);
      bus(0, 8'ha4, 0, d);
      chk("cleared", d & 32'h4f8f, 0);
      $display("registers done");
      for (int k = 0; k < 4; k++)
      begin
         c = cmds[$random(seed) & 7];
         a = $random(seed);
         fire(6'h01 << k, a, {18'h0, c});
         fire(6'h01, ~a, {18'h0, ~c});
         rst_b_in <= 1'b0;
         repeat (8) @(posedge ref_clk_in);
         rst_b_in <= 1'b1;
         bus(0, 8'ha4, 0, d);
         chk("flag", d[k], 1);
         chk("second", d[7], 1);
         chk("cmd", d[6:4], exp_cmd(c));
         chk("bus addr", baddr, a);
         bus(1, 8'ha4, 0, q);
         bus(0, 8'ha4, 0, q);
         chk("kept", q[7:0], d[7:0]);
         bus(1, 8'ha4, 32'h8f, q);
         bus(0, 8'ha4, 0, q);
         chk("unlock", q[7:0] & 8'h8f, 0);
      end
      $display("bus errors done");
      a = $random(seed);
      d = $random(seed);
      i = {7'h4f, 7'h75, d[3:0], 4'h0};
      fire(6'h10, a, i);
      fire(6'h20, ~a, ~i);
      bus(0, 8'ha4, 0, q);
      chk("fill", q[14:8], {1'b1, i[7:5], 1'b0, i[4], 1'b1});
      bus(0, 8'ha8, 0, q);
      chk("syndrome", q[13:0], i[21:8]);
      bus(0, 8'haa, 0, q);
      chk("fill addr", q[31:5], a[31:5]);
      chk("decode", {hb, lb, hd, ld}, {7'd0, 7'd31, 2'b00});
      bus(1, 8'ha4, 32'h4f00, q);
      fire(6'h10, a, {7'h40, 7'h03, 8'h0});
      bus(0, 8'ha4, 0, q);
      chk("uncorrected", q[9:8], 2'b01);
      chk("double", {hb, hd, ld}, {7'd38, 2'b01});
      bus(1, 8'ha4, 32'h4f00, q);
      fire(6'h20, a, 0);
      bus(0, 8'ha4, 0, q);
      chk("parity", q[10], 1);
      $display("fill errors done");
      a = $random(seed);
      bus(1, 8'hae, a, q);
      bus(1, 8'hb4, 1, q);
      repeat (2) @(posedge ref_clk_in);
      chk("sw check", wchk, a[13:0]);
      bus(1, 8'hb4, 0, q);
      $display("check bits done");
      conclude;
   end
endmodule // fbec_top_test
